// ### hw/csp_uart.sv
`timescale 1ns/1ps
`default_nettype none
module csp_uart
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [csp_pkg::CSP_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       rxd_i,
  input  wire logic                       cts_i,
  input  wire logic                       dcd_i,
  output logic                            txd_o,
  output logic                            rts_o,
  output logic                            dtr_o,
  output logic                            txen_o,
  output logic                            rs485_o,
  output logic                            rx_thresh_o,
  output logic                            ext_event_o
);
  import csp_pkg::*;

  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_IDLE = 4'b0010,
    RX_BITS = 4'b0100,
    RX_DONE = 4'b1000
  } csp_rxst_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_CTS  = 3'b010,
    TX_RUN  = 3'b100
  } csp_txst_t;

  logic [CSP_CTRL_W-1:0] ctrl_r;
  logic [2:0]            sy1_r;
  logic [2:0]            sy2_r;
  logic [2:0]            sy3_r;
  logic [9:0]            tick_r;
  logic [15:0]           silence_r;
  logic [15:0]           sil_cap_r;
  csp_rxst_t             rx_st_r;
  logic [17:0]           rx_cnt_r;
  logic [3:0]            rx_bit_r;
  logic [9:0]            rx_sr_r;
  csp_txst_t             tx_st_r;
  logic [10:0]           tx_sr_r;
  logic [16:0]           tx_cnt_r;
  logic [4:0]            tx_hv_r;
  logic                  tx_ph_r;
  logic [CSP_QAW-1:0]    wr_ptr_r;
  logic [CSP_QAW-1:0]    rd_ptr_r;
  logic [4:0]            q_cnt_r;
  logic                  lost_r;
  logic                  fresh_r;
  logic [31:0]           q_rd;
  logic [31:0]           rd_mux;
  logic                  bad;
  logic [7:0]            e_new;
  logic [10:0]           tx_fr;
  logic                  rts_nxt;

  function automatic logic par_of(input logic [7:0] d, input logic [2:0] m);
    logic r;
    r = 1'b0;
    case (m)
      CSP_PAR_ODD:  r = ~^d;
      CSP_PAR_EVEN: r = ^d;
      CSP_PAR_ONE:  r = 1'b1;
      default:      r = 1'b0;
    endcase
    return r;
  endfunction : par_of

  // configuration fields
  wire        f_485   = ctrl_r[CSP_F_TYPE];
  wire [3:0]  f_baud  = ctrl_r[CSP_F_BAUD +: 4];
  wire [2:0]  f_par   = ctrl_r[CSP_F_PAR +: 3];
  wire [1:0]  f_db    = ctrl_r[CSP_F_DB +: 2];
  wire [1:0]  f_stop  = ctrl_r[CSP_F_STOP +: 2];
  wire        f_ext   = ctrl_r[CSP_F_EXT];
  wire [2:0]  f_rts   = ctrl_r[CSP_F_RTS +: 3];
  wire [1:0]  f_thr   = ctrl_r[CSP_F_THR +: 2];
  wire        f_rxtx  = ctrl_r[CSP_F_RXTX];
  wire        f_dcdev = ctrl_r[CSP_F_DCDEV];
  wire        f_ctsev = ctrl_r[CSP_F_CTSEV];
  wire        f_mrts  = ctrl_r[CSP_F_MRTS];
  wire        f_mdtr  = ctrl_r[CSP_F_MDTR];

  wire        p_on  = f_par != CSP_PAR_NONE;
  wire [3:0]  nbits = 4'(f_db) + 4'd5;
  wire [3:0]  nfr   = nbits + 4'(p_on) + 4'd1;
  wire [7:0]  dmask = 8'hff >> (4'd8 - nbits);
  wire [16:0] half  = CSP_HALF_DIV[f_baud];
  wire        rx_s  = sy2_r[0];
  wire        cts_s = sy2_r[1];
  wire        dcd_s = sy2_r[2];

  // bus decode; a request completes one cycle after the access phase opens, two for an RXD read held by a queue update
  wire acc   = psel & penable & ~pready;
  wire xfer  = psel & penable & pready;
  wire a_rxd = paddr == CSP_A_RXD;
  // a queue update last cycle has not reached the read port yet
  wire hold  = fresh_r & a_rxd & ~pwrite;
  wire take  = acc & ~hold;

  wire [1:0] w_db   = pwdata[CSP_F_DB +: 2];
  wire [1:0] w_stop = pwdata[CSP_F_STOP +: 2];
  wire cfg_bad = (w_stop == CSP_STOP_RSV)
    | ((w_db == 2'h0) ? (w_stop == CSP_STOP_2) : (w_stop == CSP_STOP_15))
    | (pwdata[CSP_F_BAUD +: 4] > 4'(CSP_NBAUD - 1))
    | (pwdata[CSP_F_PAR +: 3] > CSP_PAR_ZERO)
    | (pwdata[CSP_F_RTS +: 3] > CSP_RTS_MAN);

  wire tx_idle = tx_st_r == TX_IDLE;
  wire wr_ctrl = xfer & pwrite & (paddr == CSP_A_CTRL) & ~pslverr;
  wire tx_go   = xfer & pwrite & (paddr == CSP_A_TXD) & ~pslverr;
  wire q_any   = q_cnt_r != 5'h0;
  wire pop     = xfer & ~pwrite & a_rxd & q_any;

  // receive frame decode, valid in the done state
  wire [9:0] rx_al  = rx_sr_r >> (4'd10 - nfr);
  wire [7:0] rx_ch  = rx_al[7:0] & dmask;
  wire       rx_fe  = ~rx_al[nfr - 4'd1];
  wire       rx_pe  = p_on & (rx_al[nbits] != par_of(rx_ch, f_par));
  wire       rx_brk = rx_al == 10'h0;
  wire       rx_done = rx_st_r == RX_DONE;
  wire       rx_drop = f_rxtx & ~tx_idle;
  wire       push    = rx_done & ~rx_drop;
  wire       q_full  = q_cnt_r == 5'(CSP_QDEPTH);
  wire       ovw     = push & q_full & ~pop;
  wire [31:0] q_wdata = {sil_cap_r, e_new, rx_ch};

  wire [7:0] e_or = q_rd[15:8] | (8'(lost_r) << CSP_E_FOV);
  wire [7:0] e_out = e_or | {7'h0, |e_or};
  wire [31:0] rx_word = !q_any ? 32'h0
    : f_ext ? {q_rd[31:16], e_out, q_rd[7:0]}
    : {24'h0, q_rd[7:0]};

  wire [4:0]  thr  = CSP_THR_TAB[f_thr];
  wire [31:0] stat = (32'(tx_idle ? 1'b0 : 1'b1) << CSP_S_BUSY)
    | (32'(q_any) << CSP_S_AVAIL)
    | (32'(rx_thresh_o) << CSP_S_THR)
    | (32'(cts_s) << CSP_S_CTS)
    | (32'(dcd_s) << CSP_S_DCD)
    | (32'(lost_r) << CSP_S_LOST)
    | (32'(q_cnt_r) << CSP_S_CNT);

  wire tx_end  = (tx_st_r == TX_RUN) & (tx_cnt_r == 17'h0)
    & (tx_hv_r == 5'h1);
  wire sil_rst = wr_ctrl | rx_done | tx_end;
  wire tick    = tick_r == 10'(CSP_TICK_CYC - 1);
  wire [4:0] tx_len = {nfr, 1'b0} + 5'(f_stop) + 5'd2;

  always_comb
  begin
    rd_mux = 32'h0;
    bad = 1'b0;
    if (paddr == CSP_A_CTRL)
    begin
      rd_mux = 32'(ctrl_r);
      bad = pwrite & cfg_bad;
    end
    else if (paddr == CSP_A_TXD)
      bad = pwrite & ~tx_idle;
    else if (paddr == CSP_A_STAT)
      rd_mux = stat;
    else if (a_rxd)
      rd_mux = pwrite ? 32'h0 : rx_word;
    else if (paddr == CSP_A_SIL)
      rd_mux = {16'h0, silence_r};
    else
      bad = 1'b1;
  end

  always_comb
  begin
    e_new = 8'h0;
    e_new[CSP_E_BRK] = rx_brk;
    e_new[CSP_E_FRM] = rx_fe;
    e_new[CSP_E_PAR] = rx_pe;
    e_new[CSP_E_QOV] = ovw;
  end

  // unused data positions idle high so the stop level follows right after data or parity
  always_comb
  begin
    tx_fr = {2'b11, pwdata[7:0] | ~dmask, 1'b0};
    if (p_on)
      tx_fr[nbits + 4'd1] = par_of(pwdata[7:0] & dmask, f_par);
  end

  always_comb
  begin
    case (f_rts)
      CSP_RTS_ON:  rts_nxt = 1'b1;
      CSP_RTS_REQ: rts_nxt = ~tx_idle | tx_go;
      CSP_RTS_HS:  rts_nxt = ~tx_idle | tx_go;
      CSP_RTS_MAN: rts_nxt = f_mrts;
      default:     rts_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      ctrl_r  <= CSP_CTRL_RST;
    end
    else
    begin
      pready  <= take;
      pslverr <= take & bad;
      prdata  <= take ? rd_mux : prdata;
      if (wr_ctrl)
        ctrl_r <= pwdata[CSP_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy1_r <= 3'b001;
      sy2_r <= 3'b001;
      sy3_r <= 3'b001;
    end
    else
    begin
      sy1_r <= {dcd_i, cts_i, rxd_i};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_r    <= 10'h0;
      silence_r <= 16'h0;
    end
    else
    begin
      tick_r <= (sil_rst | tick) ? 10'h0 : tick_r + 10'h1;
      if (sil_rst)
        silence_r <= 16'h0;
      else if (tick & (silence_r != CSP_SIL_MAX))
        silence_r <= silence_r + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_r   <= RX_HUNT;
      rx_cnt_r  <= 18'h0;
      rx_bit_r  <= 4'h0;
      rx_sr_r   <= 10'h0;
      sil_cap_r <= 16'h0;
    end
    else
    begin
      case (rx_st_r)
        RX_HUNT:
          if (rx_s)
            rx_st_r <= RX_IDLE;
        RX_IDLE:
          if (!rx_s)
          begin
            rx_st_r   <= RX_BITS;
            rx_cnt_r  <= 18'(half) - 18'h1;
            rx_bit_r  <= 4'h0;
            rx_sr_r   <= 10'h0;
            sil_cap_r <= silence_r;
          end
        RX_BITS:
          if (rx_cnt_r == 18'h0)
          begin
            rx_cnt_r <= {half, 1'b0} - 18'h1;
            rx_bit_r <= rx_bit_r + 4'h1;
            if ((rx_bit_r == 4'h0) & rx_s)
              rx_st_r <= RX_IDLE;
            else if (rx_bit_r == nfr)
              rx_st_r <= RX_DONE;
            if (rx_bit_r != 4'h0)
              rx_sr_r <= {rx_s, rx_sr_r[9:1]};
          end
          else
            rx_cnt_r <= rx_cnt_r - 18'h1;
        RX_DONE:
          rx_st_r <= RX_HUNT;
        default:
          rx_st_r <= RX_HUNT;
      endcase
    end
  end

  // a full queue keeps the newest characters and drops the oldest
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      q_cnt_r  <= 5'h0;
      lost_r   <= 1'b0;
      fresh_r  <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + CSP_QAW'(push);
      rd_ptr_r <= rd_ptr_r + CSP_QAW'(pop | ovw);
      q_cnt_r  <= q_cnt_r + 5'(push) - 5'(pop | ovw);
      lost_r   <= ovw | (lost_r & ~pop);
      fresh_r  <= push | pop;
    end
  end

  csp_rx_mem u_mem
  (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (push),
    .waddr   (wr_ptr_r),
    .wdata   (q_wdata),
    .raddr   (rd_ptr_r),
    .rdata   (q_rd)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_r  <= TX_IDLE;
      tx_sr_r  <= 11'h7ff;
      tx_cnt_r <= 17'h0;
      tx_hv_r  <= 5'h0;
      tx_ph_r  <= 1'b0;
    end
    else
    begin
      case (tx_st_r)
        TX_IDLE:
          if (tx_go)
          begin
            tx_sr_r  <= tx_fr;
            tx_hv_r  <= tx_len;
            tx_cnt_r <= half - 17'h1;
            tx_ph_r  <= 1'b0;
            tx_st_r  <= (f_rts == CSP_RTS_HS) ? TX_CTS : TX_RUN;
          end
        TX_CTS:
          if (cts_s)
            tx_st_r <= TX_RUN;
        TX_RUN:
          if (tx_cnt_r == 17'h0)
          begin
            tx_cnt_r <= half - 17'h1;
            tx_ph_r  <= ~tx_ph_r;
            tx_hv_r  <= tx_hv_r - 5'h1;
            if (tx_ph_r)
              tx_sr_r <= {1'b1, tx_sr_r[10:1]};
            if (tx_hv_r == 5'h1)
              tx_st_r <= TX_IDLE;
          end
          else
            tx_cnt_r <= tx_cnt_r - 17'h1;
        default:
          tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // line outputs other than rts_o, which also decodes tx_go, lag the state by one cycle, uniformly for every bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txd_o       <= 1'b1;
      rts_o       <= 1'b0;
      dtr_o       <= 1'b0;
      txen_o      <= 1'b1;
      rs485_o     <= 1'b0;
      rx_thresh_o <= 1'b0;
      ext_event_o <= 1'b0;
    end
    else
    begin
      txd_o       <= (tx_st_r == TX_RUN) ? tx_sr_r[0] : 1'b1;
      rts_o       <= rts_nxt;
      dtr_o       <= (f_rts == CSP_RTS_MAN) & f_mdtr;
      txen_o      <= ~f_485 | (tx_st_r == TX_RUN);
      rs485_o     <= f_485;
      rx_thresh_o <= q_cnt_r >= thr;
      ext_event_o <= (f_ctsev & (sy2_r[1] ^ sy3_r[1]))
        | (f_dcdev & (sy2_r[2] ^ sy3_r[2]));
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cfg_wr;
    wr_ctrl;
  endsequence

  sequence s_tx_start;
    tx_go && (f_rts != CSP_RTS_HS);
  endsequence

  a_cfg_legal: assert property (
    (f_stop != CSP_STOP_RSV)
    && ((f_db == 2'h0) ? (f_stop != CSP_STOP_2) : (f_stop != CSP_STOP_15)))
    else $error("illegal stop and data bit combination held");
  a_sil_sat: assert property (
    (silence_r == CSP_SIL_MAX) && !sil_rst |=> silence_r == CSP_SIL_MAX)
    else $error("silence count wrapped");
  a_sil_cfg: assert property (s_cfg_wr |=> silence_r == 16'h0)
    else $error("silence not restarted by configuration");
  a_err_summary: assert property (
    pready && !pwrite && a_rxd && f_ext && !pslverr
    |-> prdata[8] == |prdata[15:11])
    else $error("error summary bit disagrees with error flags");
  a_qov_mark: assert property (ovw |-> q_wdata[8 + CSP_E_QOV])
    else $error("overwriting character not flagged");
  a_frame_err: assert property (
    push && rx_fe |-> q_wdata[8 + CSP_E_FRM])
    else $error("low stop bit not flagged");
  a_cts_wait: assert property (
    (tx_st_r == TX_CTS) && !cts_s |=> txd_o && (tx_st_r != TX_RUN))
    else $error("transmit started without clear to send");
  a_rts_req: assert property (
    (f_rts == CSP_RTS_REQ) && (tx_st_r == TX_RUN) && $stable(f_rts)
    |=> rts_o)
    else $error("request to send low during transmission");
  a_rts_off: assert property (
    (f_rts == CSP_RTS_OFF) |=> !rts_o)
    else $error("request to send active in off mode");
  a_rx_drop: assert property (
    rx_done && rx_drop && !pop |=> $stable(q_cnt_r))
    else $error("character kept while transmitting");
  a_tx_start: assert property (s_tx_start |=> ##1 !txd_o)
    else $error("start bit not driven low");
endmodule : csp_uart
`default_nettype wire

// ### hw/csp_pkg.sv
package csp_pkg;
  localparam int unsigned CSP_CLK_HZ   = 100_000_000;
  localparam int unsigned CSP_CLK_NS   = 10;
  localparam int unsigned CSP_TICK_NS  = 10_000;
  localparam int unsigned CSP_TICK_CYC = CSP_TICK_NS / CSP_CLK_NS;
  localparam int          CSP_AW       = 8;

  localparam logic [7:0] CSP_A_CTRL = 8'h00;
  localparam logic [7:0] CSP_A_TXD  = 8'h04;
  localparam logic [7:0] CSP_A_STAT = 8'h08;
  localparam logic [7:0] CSP_A_RXD  = 8'h0c;
  localparam logic [7:0] CSP_A_SIL  = 8'h10;

  localparam int CSP_F_TYPE  = 0;
  localparam int CSP_F_BAUD  = 1;
  localparam int CSP_F_PAR   = 5;
  localparam int CSP_F_DB    = 8;
  localparam int CSP_F_STOP  = 10;
  localparam int CSP_F_EXT   = 12;
  localparam int CSP_F_RTS   = 13;
  localparam int CSP_F_THR   = 16;
  localparam int CSP_F_RXTX  = 18;
  localparam int CSP_F_DCDEV = 19;
  localparam int CSP_F_CTSEV = 20;
  localparam int CSP_F_MRTS  = 21;
  localparam int CSP_F_MDTR  = 22;
  localparam int CSP_CTRL_W  = 23;
  // 115200, no parity, 8 data, 1 stop, normal, RTS off, threshold 8
  localparam logic [CSP_CTRL_W-1:0] CSP_CTRL_RST = 23'h1a0312;

  localparam int CSP_S_BUSY  = 0;
  localparam int CSP_S_AVAIL = 1;
  localparam int CSP_S_THR   = 2;
  localparam int CSP_S_CTS   = 3;
  localparam int CSP_S_DCD   = 4;
  localparam int CSP_S_LOST  = 5;
  localparam int CSP_S_CNT   = 8;

  localparam int CSP_E_BRK = 3;
  localparam int CSP_E_FRM = 4;
  localparam int CSP_E_PAR = 5;
  localparam int CSP_E_FOV = 6;
  localparam int CSP_E_QOV = 7;

  typedef enum logic [2:0] {
    CSP_PAR_NONE = 3'h0,
    CSP_PAR_ODD  = 3'h1,
    CSP_PAR_EVEN = 3'h2,
    CSP_PAR_ONE  = 3'h3,
    CSP_PAR_ZERO = 3'h4
  } csp_par_t;

  typedef enum logic [2:0] {
    CSP_RTS_OFF = 3'h0,
    CSP_RTS_ON  = 3'h1,
    CSP_RTS_REQ = 3'h2,
    CSP_RTS_HS  = 3'h3,
    CSP_RTS_MAN = 3'h4
  } csp_rts_t;

  localparam logic [1:0] CSP_STOP_1   = 2'h0;
  localparam logic [1:0] CSP_STOP_15  = 2'h1;
  localparam logic [1:0] CSP_STOP_2   = 2'h2;
  localparam logic [1:0] CSP_STOP_RSV = 2'h3;

  localparam int CSP_NBAUD = 10;
  // half a bit time in clock cycles, one entry per rate code
  localparam logic [16:0] CSP_HALF_DIV [CSP_NBAUD] = '{
    17'(CSP_CLK_HZ / (2 * 600)),   17'(CSP_CLK_HZ / (2 * 1200)),
    17'(CSP_CLK_HZ / (2 * 1800)),  17'(CSP_CLK_HZ / (2 * 2400)),
    17'(CSP_CLK_HZ / (2 * 4800)),  17'(CSP_CLK_HZ / (2 * 9600)),
    17'(CSP_CLK_HZ / (2 * 19200)), 17'(CSP_CLK_HZ / (2 * 38400)),
    17'(CSP_CLK_HZ / (2 * 57600)), 17'(CSP_CLK_HZ / (2 * 115200))
  };
  localparam logic [4:0] CSP_THR_TAB [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};

  localparam int          CSP_QDEPTH  = 16;
  localparam int          CSP_QAW     = 4;
  localparam int          CSP_QW      = 32;
  localparam logic [15:0] CSP_SIL_MAX = 16'hffff;
endpackage : csp_pkg

// ### hw/csp_rx_mem.sv
`timescale 1ns/1ps
`default_nettype none
module csp_rx_mem
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        we,
  input  wire logic [csp_pkg::CSP_QAW-1:0] waddr,
  input  wire logic [csp_pkg::CSP_QW-1:0]  wdata,
  input  wire logic [csp_pkg::CSP_QAW-1:0] raddr,
  output logic      [csp_pkg::CSP_QW-1:0]  rdata
);
  import csp_pkg::*;

  logic [CSP_QW-1:0] mem_r [CSP_QDEPTH];

  always_ff @(posedge pclk)
  begin
    if (we)
      mem_r[waddr] <= wdata;
  end

  // read port is registered; data follows raddr one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= '0;
    else
      rdata <= mem_r[raddr];
  end
endmodule : csp_rx_mem
`default_nettype wire

// ### test/csp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module csp_line_model
#(
  parameter int BIT = 868
)
(
  input  wire logic pclk,
  input  wire logic txd_i,
  output logic      rxd_o,
  output logic      cts_o
);
  int unsigned nbits = 8;
  logic        paren = 1'b0;
  logic [7:0]  got_data;
  logic        got_par;
  logic        got_stop;
  int unsigned frames = 0;
  int          k;

  initial
  begin
    rxd_o = 1'b1;
    cts_o = 1'b0;
  end

  task automatic set_cts(input logic v);
    cts_o <= v;
  endtask : set_cts

  task automatic send(input logic [7:0] d, input logic p, input logic stp);
    int i;
    begin
      rxd_o <= 1'b0;
      repeat (BIT) @(posedge pclk);
      for (i = 0; i < nbits; i++)
      begin
        rxd_o <= d[i];
        repeat (BIT) @(posedge pclk);
      end
      if (paren)
      begin
        rxd_o <= p;
        repeat (BIT) @(posedge pclk);
      end
      rxd_o <= stp;
      repeat (BIT) @(posedge pclk);
      // one idle bit so the receiver can re-arm before the next frame
      rxd_o <= 1'b1;
      repeat (BIT) @(posedge pclk);
    end
  endtask : send

  always
  begin
    @(negedge txd_i);
    got_data = 8'h00;
    repeat (BIT / 2) @(posedge pclk);
    for (k = 0; k < nbits; k++)
    begin
      repeat (BIT) @(posedge pclk);
      got_data[k] = txd_i;
    end
    if (paren)
    begin
      repeat (BIT) @(posedge pclk);
      got_par = txd_i;
    end
    repeat (BIT) @(posedge pclk);
    got_stop = txd_i;
    frames++;
  end
endmodule : csp_line_model
`default_nettype wire

// ### test/csp_uart_test.sv
`timescale 1ns/1ps
`default_nettype none
module csp_uart_test;
  import csp_pkg::*;
  localparam int BIT = 868;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        cts;
  logic        dcd = 1'b0;
  logic        txd;
  logic        rts;
  logic        dtr;
  logic        txen;
  logic        rs485;
  logic        thr;
  logic        ev;
  int          num_errors = 0;
  int          checks = 0;

  always #5 pclk = ~pclk;

  csp_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_i(rxd),
    .cts_i(cts), .dcd_i(dcd), .txd_o(txd), .rts_o(rts), .dtr_o(dtr),
    .txen_o(txen), .rs485_o(rs485), .rx_thresh_o(thr), .ext_event_o(ev));

  csp_line_model #(.BIT(BIT)) line (.pclk(pclk), .txd_i(txd), .rxd_o(rxd),
    .cts_o(cts));

  task automatic results;
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // entered just after a rising edge, returns one edge after the answer
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    begin
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      if (n == 20)
        num_errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  task automatic wait_frame(input int unsigned f);
    int c;
    begin
      c = 0;
      while (line.frames < f && c < 20000)
      begin
        @(posedge pclk);
        c++;
      end
      if (c == 20000)
        num_errors++;
    end
  endtask : wait_frame

  function automatic logic [31:0] cfg(input logic [2:0] par,
      input logic [1:0] db, input logic [1:0] st, input logic ext,
      input logic [2:0] rm, input logic [1:0] th);
    cfg = 32'h0018_0012 | (32'(par) << CSP_F_PAR) | (32'(db) << CSP_F_DB)
        | (32'(st) << CSP_F_STOP) | (32'(ext) << CSP_F_EXT)
        | (32'(rm) << CSP_F_RTS) | (32'(th) << CSP_F_THR);
  endfunction : cfg

  initial
  begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    results();
  end

  initial
  begin
    logic [31:0] r;
    logic        e;
    int          c;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CSP_A_CTRL, 32'h0, r, e);
    check(r, 32'(CSP_CTRL_RST));
    check(32'({rs485, rts, txd}), 32'h1);
    apb(1'b0, 8'h14, 32'h0, r, e);
    check(32'(e), 32'h1);
    for (int db = 0; db < 4; db++)
      for (int st = 0; st < 3; st++)
      begin
        apb(1'b1, CSP_A_CTRL, cfg(3'h0, 2'(db), 2'(st), 1'b0, 3'h0, 2'h3),
            r, e);
        check(32'(e), 32'((db == 0) ? (st == 2) : (st == 1)));
      end
    // request mode on the RS-485 driver, 7 bits, odd parity, 2 stop
    apb(1'b1, CSP_A_CTRL, cfg(CSP_PAR_ODD, 2'h2, CSP_STOP_2, 1'b0,
        CSP_RTS_REQ, 2'h3) | 32'h1, r, e);
    line.nbits = 7;
    line.paren = 1'b1;
    // line outputs follow the new configuration one edge later
    @(posedge pclk);
    check(32'({rs485, txen, rts}), 32'h4);
    apb(1'b1, CSP_A_TXD, 32'h5a, r, e);
    check(32'(e), 32'h0);
    apb(1'b1, CSP_A_TXD, 32'h11, r, e);
    check(32'(e), 32'h1);
    check(32'({txen, rts}), 32'h3);
    wait_frame(1);
    check(32'({line.got_stop, line.got_par, line.got_data}), 32'h35a);
    repeat (3 * BIT) @(posedge pclk);
    check(32'({txen, rts}), 32'h0);
    // handshake: send held until the partner grants
    apb(1'b1, CSP_A_CTRL, cfg(CSP_PAR_NONE, 2'h3, CSP_STOP_1, 1'b0,
        CSP_RTS_HS, 2'h3), r, e);
    line.nbits = 8;
    line.paren = 1'b0;
    apb(1'b1, CSP_A_TXD, 32'hc3, r, e);
    repeat (20) @(posedge pclk);
    check(32'({rts, txd}), 32'h3);
    line.set_cts(1'b1);
    wait_frame(2);
    check(32'(line.got_data), 32'hc3);
    line.set_cts(1'b0);
    // let the clear-to-send event pass so only the carrier change is seen
    repeat (8) @(posedge pclk);
    dcd <= 1'b1;
    c = 0;
    while (ev !== 1'b1 && c < 8)
    begin
      @(posedge pclk);
      c++;
    end
    check(32'(ev), 32'h1);
    // the stop bit must leave the line first, or its end restarts silence
    repeat (BIT) @(posedge pclk);
    // extended mode, even parity, threshold of one byte
    apb(1'b1, CSP_A_CTRL, cfg(CSP_PAR_EVEN, 2'h3, CSP_STOP_1, 1'b1,
        CSP_RTS_OFF, 2'h0), r, e);
    line.paren = 1'b1;
    repeat (5000) @(posedge pclk);
    line.send(8'h3c, ^8'h3c, 1'b1);
    check(32'(thr), 32'h1);
    apb(1'b0, CSP_A_RXD, 32'h0, r, e);
    check(32'(r[15:0]), 32'h3c);
    check(32'(r[31:16] >= 16'd5 && r[31:16] <= 16'd6), 32'h1);
    @(posedge pclk);
    check(32'(thr), 32'h0);
    line.send(8'h81, ~^8'h81, 1'b1);
    apb(1'b0, CSP_A_RXD, 32'h0, r, e);
    check(32'(r[15:0]), 32'h2181);
    line.send(8'h55, ^8'h55, 1'b0);
    apb(1'b0, CSP_A_RXD, 32'h0, r, e);
    check(32'(r[15:0]), 32'h1155);
    repeat (3000) @(posedge pclk);
    apb(1'b0, CSP_A_SIL, 32'h0, r, e);
    check(32'(r >= 32'd4 && r <= 32'd5), 32'h1);
    // manual lines, two stop bits, bytes received while sending dropped
    apb(1'b1, CSP_A_CTRL, cfg(CSP_PAR_EVEN, 2'h3, CSP_STOP_2, 1'b1,
        CSP_RTS_MAN, 2'h0) | (32'h1 << CSP_F_RXTX)
        | (32'h1 << CSP_F_MRTS) | (32'h1 << CSP_F_MDTR), r, e);
    @(posedge pclk);
    check(32'({dtr, rts}), 32'h3);
    apb(1'b1, CSP_A_TXD, 32'h99, r, e);
    line.send(8'h42, ^8'h42, 1'b1);
    check(32'(line.got_data), 32'h99);
    apb(1'b0, CSP_A_RXD, 32'h0, r, e);
    check(r, 32'h0);
    results();
  end
endmodule : csp_uart_test
`default_nettype wire
